/* rtl/lfs_ctrl.sv */
// Purpose: Lock, fuse and signature control with parallel command dispatch.
// Assumes: All pins synchronous to ref_clk; fuse values held in flops.
// Notes: Crystal and write strobes act on their edges, output enable on its level; pulse width is not checked.
// Functional notes
// - Boot lock mode 1 puts no limit on boot section writes or reads.
// - Boot lock mode 2 blocks self-programming writes to the boot section.
// - Mode 3 blocks boot writes, app reads of boot; may mask interrupts.
// - Mode 4 blocks app reads of boot, allows writes; may mask interrupts.
// - Thirteen fuses in two groups; serial path cannot change serial enable.
// - Debug on only when debug and scan fuses are both programmed.
// - Programmed debug fuse keeps clocks running in every sleep mode.
// - Programmed scan fuse enables the scan port; default programmed.
// - Programmed serial enable permits serial downloading; default programmed.
// - EEPROM preserve keeps EEPROM over erase; refused if any lock set.
// - Two boot size fuses pick boot section size and start; default 11.
// - Boot reset fuse programmed moves reset vector to boot start, else 0.
// - Brown-out level fuse picks threshold and start-up times; default 1.
// - Brown-out enable fuse programmed turns on the detector.
// - Four clock select fuses pick source and start-up; default 0010.
// - Chip erase leaves every fuse unchanged.
// - Programmed memory lock bit one freezes all fuses.
// - Three signature bytes at addresses 0 to 2, readable serial and parallel.
// - Calibration byte is the high byte of signature address 0.
// - Crystal strobe does the selected action; write/enable strobes run command.
// - Action select: 00 address, 01 data, 10 command, 11 idle.
// - Command byte uses one-hot style codes.
// - Ready/busy low while programming, high when ready.
`timescale 1ns/1ps
module lfs_ctrl #(
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identity value.
    parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identity value.
    parameter logic [7:0] SIG_BYTE2 = 8'h07, // Arbitrary identity value.
    parameter logic [7:0] CAL_BYTE = 8'h80,
    parameter int BUSY_CYC = lfs_pkg::PROG_BUSY_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Parallel programming pins
    input wire logic prog_mode_en,
    input wire logic crystal_input_strobe,
    input wire logic action_select_hi,
    input wire logic action_select_lo,
    input wire logic byte_select_one,
    input wire logic byte_select_two,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic ready_busy_out,
    // Serial and scan fuse and signature access
    input wire logic ext_fuse_wr,
    input wire logic ext_fuse_hi,
    input wire logic ext_fuse_serial,
    input wire logic [7:0] ext_fuse_data,
    input wire logic [1:0] ext_sig_addr,
    input wire logic ext_sig_hi,
    output logic [7:0] ext_sig_data,
    // Memory write and erase requests
    output logic nvm_wr_pulse,
    output logic nvm_wr_eeprom,
    output logic [15:0] nvm_addr,
    output logic [15:0] nvm_wdata,
    output logic erase_flash_pulse,
    output logic erase_eeprom_pulse,
    // Core access checks
    input wire logic spm_wr_req,
    input wire logic spm_to_boot,
    input wire logic lpm_rd_req,
    input wire logic lpm_from_boot,
    input wire logic exec_in_boot,
    input wire logic ivec_in_boot,
    output logic spm_wr_allow,
    output logic lpm_rd_allow,
    output logic irq_allow,
    // Decoded fuse functions
    output logic ocd_enable,
    output logic sleep_clk_keep,
    output logic scan_port_enable,
    output logic serial_prog_enable,
    output logic eeprom_preserve,
    output logic [1:0] boot_size,
    output logic [15:0] reset_vector,
    output logic brownout_level,
    output logic brownout_enable,
    output logic [3:0] clock_select
);
    import lfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // A fuse write may only program or erase bits while no lock blocks it.
    function automatic logic [6:0] fuse_hi_next(input logic [6:0] old_v,
        input logic [6:0] new_v, input logic [5:0] lock_v,
        input logic serial);
        logic [6:0] r;
        r = new_v;
        if (lock_v != LOCK_RST) begin
            r[FH_EEKEEP] = old_v[FH_EEKEEP];
        end
        if (serial) begin
            r[FH_SPROG] = old_v[FH_SPROG];
        end
        return r;
    endfunction : fuse_hi_next

    function automatic logic [7:0] sig_byte(input logic [1:0] a,
        input logic hi);
        logic [7:0] r;
        r = 8'h00;
        if (hi) begin
            r = (a == 2'h0) ? CAL_BYTE : 8'h00;
        end else begin
            case (a)
                2'h0: r = SIG_BYTE0;
                2'h1: r = SIG_BYTE1;
                2'h2: r = SIG_BYTE2;
                default: r = 8'h00;
            endcase
        end
        return r;
    endfunction : sig_byte

    ////////////////////////////////////////////////////////////////////////
    // State.

    lfs_state_t state_q, state_d;
    logic [15:0] busy_cnt_q, busy_cnt_d;
    logic xtal_q, wr_n_q;
    logic [7:0] cmd_q, cmd_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic [6:0] fuse_hi_q, fuse_hi_d;
    logic [5:0] fuse_lo_q, fuse_lo_d;
    logic [5:0] lock_q, lock_d;
    logic [7:0] dout_q, dout_d;
    logic doe_n_q, doe_n_d;
    logic [7:0] esig_q, esig_d;
    logic nwr_q, nwr_d, nee_q, nee_d, efl_q, efl_d, eee_q, eee_d;
    logic [15:0] naddr_q, naddr_d, ndata_q, ndata_d;

    logic xtal_rise, wr_fall, fuse_locked, mem_locked;
    lfs_action_t act;
    logic [1:0] blk;

    assign xtal_rise = prog_mode_en && crystal_input_strobe && !xtal_q;
    assign wr_fall = prog_mode_en && !wr_n && wr_n_q;
    assign act = lfs_action_t'({action_select_hi, action_select_lo});
    assign fuse_locked = !lock_q[LK_ML1];
    assign mem_locked = !lock_q[LK_ML1];
    assign blk = lock_q[LK_BLB11 +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        state_d = state_q;
        busy_cnt_d = busy_cnt_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        data_d = data_q;
        fuse_hi_d = fuse_hi_q;
        fuse_lo_d = fuse_lo_q;
        lock_d = lock_q;
        nwr_d = 1'b0;
        nee_d = 1'b0;
        efl_d = 1'b0;
        eee_d = 1'b0;
        naddr_d = naddr_q;
        ndata_d = ndata_q;
        esig_d = sig_byte(ext_sig_addr, ext_sig_hi);
        doe_n_d = !(prog_mode_en && !oe_n);
        dout_d = dout_q;
        if (xtal_rise) begin
            case (act)
                ACT_LOAD_ADDR: begin
                    if (byte_select_one) begin
                        addr_d[15:8] = data_in;
                    end else begin
                        addr_d[7:0] = data_in;
                    end
                end
                ACT_LOAD_DATA: begin
                    if (byte_select_one) begin
                        data_d[15:8] = data_in;
                    end else begin
                        data_d[7:0] = data_in;
                    end
                end
                ACT_LOAD_CMD: cmd_d = data_in;
                default: ;
            endcase
        end
        // Output reads follow the loaded command while output enable is low.
        if (prog_mode_en && !oe_n) begin
            case (cmd_q)
                CMD_RD_SIG: dout_d = sig_byte(addr_q[1:0], byte_select_one);
                CMD_RD_FUSE_LOCK: begin
                    if (byte_select_two) begin
                        dout_d = {2'b11, lock_q};
                    end else if (byte_select_one) begin
                        dout_d = {1'b1, fuse_hi_q};
                    end else begin
                        dout_d = {2'b11, fuse_lo_q};
                    end
                end
                default: dout_d = 8'hff;
            endcase
        end
        case (state_q)
            ST_IDLE: begin
                if (wr_fall) begin
                    state_d = ST_BUSY;
                    busy_cnt_d = 16'(BUSY_CYC - 1);
                    case (cmd_q)
                        CMD_CHIP_ERASE: begin
                            // Fuses stay; only memories and locks clear.
                            efl_d = 1'b1;
                            eee_d = fuse_hi_q[FH_EEKEEP];
                            lock_d = LOCK_RST;
                        end
                        CMD_WR_FUSE: begin
                            if (!fuse_locked) begin
                                if (byte_select_one) begin
                                    fuse_hi_d = fuse_hi_next(fuse_hi_q,
                                        data_q[6:0], lock_q, 1'b0);
                                end else begin
                                    fuse_lo_d = data_q[5:0];
                                end
                            end
                        end
                        // Lock bits can only be programmed, never erased here.
                        CMD_WR_LOCK: lock_d = lock_q & data_q[5:0];
                        CMD_WR_FLASH, CMD_WR_EEPROM: begin
                            if (!mem_locked) begin
                                nwr_d = 1'b1;
                                nee_d = cmd_q[0];
                                naddr_d = addr_q;
                                ndata_d = data_q;
                            end
                        end
                        default: state_d = ST_IDLE;
                    endcase
                end else if (ext_fuse_wr && !fuse_locked) begin
                    if (ext_fuse_hi) begin
                        fuse_hi_d = fuse_hi_next(fuse_hi_q,
                            ext_fuse_data[6:0], lock_q, ext_fuse_serial);
                    end else begin
                        fuse_lo_d = ext_fuse_data[5:0];
                    end
                end
            end
            ST_BUSY: begin
                if (busy_cnt_q == 16'h0000) begin
                    state_d = ST_IDLE;
                end else begin
                    busy_cnt_d = busy_cnt_q - 16'h0001;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            busy_cnt_q <= 16'h0000;
            xtal_q <= 1'b0;
            wr_n_q <= 1'b1;
            cmd_q <= CMD_RST;
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
            fuse_hi_q <= FUSE_HI_RST;
            fuse_lo_q <= FUSE_LO_RST;
            lock_q <= LOCK_RST;
            dout_q <= 8'h00;
            doe_n_q <= 1'b1;
            esig_q <= 8'h00;
            nwr_q <= 1'b0;
            nee_q <= 1'b0;
            efl_q <= 1'b0;
            eee_q <= 1'b0;
            naddr_q <= 16'h0000;
            ndata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            busy_cnt_q <= busy_cnt_d;
            xtal_q <= crystal_input_strobe;
            wr_n_q <= wr_n;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            data_q <= data_d;
            fuse_hi_q <= fuse_hi_d;
            fuse_lo_q <= fuse_lo_d;
            lock_q <= lock_d;
            dout_q <= dout_d;
            doe_n_q <= doe_n_d;
            esig_q <= esig_d;
            nwr_q <= nwr_d;
            nee_q <= nee_d;
            efl_q <= efl_d;
            eee_q <= eee_d;
            naddr_q <= naddr_d;
            ndata_q <= ndata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign data_out = dout_q;
    assign data_oe_n = doe_n_q;
    assign ready_busy_out = (state_q == ST_IDLE);
    assign ext_sig_data = esig_q;
    assign nvm_wr_pulse = nwr_q;
    assign nvm_wr_eeprom = nee_q;
    assign nvm_addr = naddr_q;
    assign nvm_wdata = ndata_q;
    assign erase_flash_pulse = efl_q;
    assign erase_eeprom_pulse = eee_q;

    // Boot lock decode; the other partition is never restricted here.
    assign spm_wr_allow = !(spm_wr_req && spm_to_boot &&
        (blk == BLK_MODE2 || blk == BLK_MODE3));
    assign lpm_rd_allow = !(lpm_rd_req && !lpm_from_boot &&
        (blk == BLK_MODE3 || blk == BLK_MODE4));
    assign irq_allow = !(exec_in_boot && !ivec_in_boot &&
        (blk == BLK_MODE3 || blk == BLK_MODE4));

    assign ocd_enable = !fuse_hi_q[FH_DEBUG] && !fuse_hi_q[FH_SCAN];
    assign sleep_clk_keep = !fuse_hi_q[FH_DEBUG];
    assign scan_port_enable = !fuse_hi_q[FH_SCAN];
    assign serial_prog_enable = !fuse_hi_q[FH_SPROG];
    assign eeprom_preserve = !fuse_hi_q[FH_EEKEEP];
    assign boot_size = fuse_hi_q[FH_BSIZE_LSB +: 2];
    assign reset_vector = fuse_hi_q[FH_BOOTVEC] ? RESET_VEC_APP :
        BOOT_START[boot_size];
    assign brownout_level = fuse_lo_q[FL_BO_LEVEL];
    assign brownout_enable = !fuse_lo_q[FL_BO_EN];
    assign clock_select = fuse_lo_q[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_wr_cmd;
        state_q == ST_IDLE && wr_fall && (cmd_q == CMD_CHIP_ERASE ||
            cmd_q == CMD_WR_FUSE || cmd_q == CMD_WR_LOCK);
    endsequence

    sequence s_busy_run;
        !ready_busy_out [*8] ##1 !ready_busy_out;
    endsequence

    property p_busy_after_wr;
        s_wr_cmd |=> s_busy_run;
    endproperty
    a_busy_after_wr: assert property (p_busy_after_wr)
        else $error("ready/busy not low after write command");

    property p_boot_wr_block;
        (blk == BLK_MODE2 && spm_wr_req && spm_to_boot) |-> !spm_wr_allow;
    endproperty
    a_boot_wr_block: assert property (p_boot_wr_block)
        else $error("boot write passed in lock mode 2");

    property p_mode1_free;
        blk == BLK_MODE1 |-> spm_wr_allow && lpm_rd_allow && irq_allow;
    endproperty
    a_mode1_free: assert property (p_mode1_free)
        else $error("restriction seen in boot lock mode 1");

    property p_mode3_block;
        (blk == BLK_MODE3 && lpm_rd_req && !lpm_from_boot) |->
            !lpm_rd_allow &&
            (spm_to_boot && spm_wr_req ? !spm_wr_allow : 1'b1);
    endproperty
    a_mode3_block: assert property (p_mode3_block)
        else $error("mode 3 access not blocked");

    property p_mode4_wr_ok;
        blk == BLK_MODE4 |-> spm_wr_allow &&
            (exec_in_boot && !ivec_in_boot ? !irq_allow : irq_allow);
    endproperty
    a_mode4_wr_ok: assert property (p_mode4_wr_ok)
        else $error("mode 4 write or interrupt gating wrong");

    property p_fuse_frozen;
        fuse_locked |=> $stable(fuse_hi_q) && $stable(fuse_lo_q);
    endproperty
    a_fuse_frozen: assert property (p_fuse_frozen)
        else $error("fuse changed while locked");

    property p_erase_keeps_fuse;
        (state_q == ST_IDLE && wr_fall && cmd_q == CMD_CHIP_ERASE) |=>
            $stable(fuse_hi_q) && $stable(fuse_lo_q) && erase_flash_pulse;
    endproperty
    a_erase_keeps_fuse: assert property (p_erase_keeps_fuse)
        else $error("chip erase altered fuses");

    property p_serial_sprog;
        (state_q == ST_IDLE && !wr_fall && ext_fuse_wr && ext_fuse_serial)
            |=> $stable(fuse_hi_q[FH_SPROG]);
    endproperty
    a_serial_sprog: assert property (p_serial_sprog)
        else $error("serial path changed serial enable fuse");

    property p_cmd_load;
        (xtal_rise && act == ACT_LOAD_CMD) |=> cmd_q == $past(data_in);
    endproperty
    a_cmd_load: assert property (p_cmd_load)
        else $error("command byte not loaded");

    property p_sig_read;
        ext_sig_addr == 2'h1 && !ext_sig_hi |=> ext_sig_data == SIG_BYTE1;
    endproperty
    a_sig_read: assert property (p_sig_read)
        else $error("signature byte 1 wrong");

    property p_ocd;
        ocd_enable == (sleep_clk_keep && scan_port_enable);
    endproperty
    a_ocd: assert property (p_ocd)
        else $error("debug enable decode wrong");

endmodule : lfs_ctrl

/* rtl/lfs_pkg.sv */
// Purpose: Shared constants and types of the lock, fuse and signature block.
// Assumes: Programmed bits read as 0, unprogrammed bits read as 1.
// Notes: Fuse and lock bit positions here are shared by all users.
package lfs_pkg;

    // Fuse high group, 7 bits.
    localparam int FH_DEBUG = 6;
    localparam int FH_SCAN = 5;
    localparam int FH_SPROG = 4;
    localparam int FH_EEKEEP = 3;
    localparam int FH_BSIZE_LSB = 1;
    localparam int FH_BOOTVEC = 0;
    localparam logic [6:0] FUSE_HI_RST = 7'h4f;

    // Fuse low group, 6 bits.
    localparam int FL_BO_LEVEL = 5;
    localparam int FL_BO_EN = 4;
    localparam logic [5:0] FUSE_LO_RST = 6'h32;

    // Lock byte: memory lock pair, then two boot lock pairs.
    localparam int LK_ML1 = 0;
    localparam int LK_BLB11 = 4;
    localparam logic [5:0] LOCK_RST = 6'h3f;

    // Boot lock field values (upper bit, lower bit).
    localparam logic [1:0] BLK_MODE1 = 2'h3;
    localparam logic [1:0] BLK_MODE2 = 2'h2;
    localparam logic [1:0] BLK_MODE3 = 2'h0;
    localparam logic [1:0] BLK_MODE4 = 2'h1;

    // Boot section start word address per boot size code.
    localparam logic [3:0][15:0] BOOT_START =
        {16'h3f00, 16'h3e00, 16'h3c00, 16'h3800};
    localparam logic [15:0] RESET_VEC_APP = 16'h0000;

    // Command byte codes.
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
    localparam logic [7:0] CMD_RST = 8'h00;

    // Cycles the ready/busy pin stays low after a write type command.
    localparam int PROG_BUSY_CYC = 16;

    typedef enum logic [1:0] {
        ACT_LOAD_ADDR = 2'h0,
        ACT_LOAD_DATA = 2'h1,
        ACT_LOAD_CMD = 2'h2,
        ACT_IDLE = 2'h3
    } lfs_action_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } lfs_state_t;

endpackage : lfs_pkg

/* dv/lfs_prog_model.sv */
// Purpose: Parallel programmer model facing the lock and fuse block.
// Assumes: The bench calls one task at a time.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ps
module lfs_prog_model #(
    parameter int PULSE_CYC = 100
) (
    // Clock and device status
    input wire logic ref_clk,
    input wire logic ready_busy_out,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    // Programming pins
    output logic crystal_input_strobe,
    output logic action_select_hi,
    output logic action_select_lo,
    output logic byte_select_one,
    output logic wr_n,
    output logic oe_n,
    output logic [7:0] data_in
);
    import lfs_pkg::*;
    initial begin
        crystal_input_strobe = 1'b0;
        {action_select_hi, action_select_lo} = ACT_IDLE;
        byte_select_one = 1'b0;
        wr_n = 1'b1;
        oe_n = 1'b1;
        data_in = 8'h00;
    end
    ////////////////////////////////////////
    // Every pulse is stretched to the minimum width at this clock rate.
    task automatic xload(input lfs_action_t act, input logic bs1,
        input logic [7:0] d);
        @(posedge ref_clk);
        {action_select_hi, action_select_lo} <= act;
        byte_select_one <= bs1;
        data_in <= d;
        @(posedge ref_clk);
        crystal_input_strobe <= 1'b1;
        repeat (PULSE_CYC) @(posedge ref_clk);
        crystal_input_strobe <= 1'b0;
        @(posedge ref_clk);
        {action_select_hi, action_select_lo} <= ACT_IDLE;
        data_in <= ~d;
    endtask : xload
    task automatic cmd(input logic [7:0] c);
        xload(ACT_LOAD_CMD, 1'b0, c);
    endtask : cmd
    // A new command is not started before ready returns or 1000 cycles pass.
    task automatic wr(input logic bs1, output int busy);
        int n;
        busy = 0;
        n = 0;
        @(posedge ref_clk);
        byte_select_one <= bs1;
        wr_n <= 1'b0;
        repeat (PULSE_CYC) begin
            @(posedge ref_clk);
            if (ready_busy_out === 1'b0) busy++;
        end
        wr_n <= 1'b1;
        while (ready_busy_out !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wr
    task automatic rd(input logic bs1, output logic [7:0] d,
        output logic oen);
        @(posedge ref_clk);
        byte_select_one <= bs1;
        oe_n <= 1'b0;
        repeat (PULSE_CYC) @(posedge ref_clk);
        d = data_out;
        oen = data_oe_n;
        oe_n <= 1'b1;
    endtask : rd
endmodule : lfs_prog_model

/* dv/test_lfs_ctrl.sv */
// Purpose: Self-checking bench of the lock, fuse and signature block.
// Assumes: Programmer model drives the parallel pins.
// Notes: Fuses are written first, then again after lock bits to check that the locks refuse them.
`timescale 1ns/1ps
module test_lfs_ctrl;
    import lfs_pkg::*;
    localparam logic [7:0] SIG0 = 8'h6b; // Arbitrary identity value.
    localparam logic [7:0] SIG1 = 8'h2d; // Arbitrary identity value.
    localparam logic [7:0] SIG2 = 8'h4e; // Arbitrary identity value.
    localparam logic [7:0] CAL = 8'h9c;
    logic [7:0] sig [3] = '{SIG0, SIG1, SIG2};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic prog_mode_en = 1'b1, byte_select_two = 1'b0;
    logic crystal_input_strobe, action_select_hi, action_select_lo;
    logic byte_select_one, wr_n, oe_n, data_oe_n, ready_busy_out;
    logic [7:0] data_in, data_out, ext_sig_data;
    logic [7:0] ext_fuse_data = 8'h00;
    logic ext_fuse_wr = 1'b0, ext_fuse_hi = 1'b0, ext_fuse_serial = 1'b0;
    logic [1:0] ext_sig_addr = 2'h0;
    logic ext_sig_hi = 1'b0, spm_wr_req = 1'b1, spm_to_boot = 1'b1;
    logic lpm_rd_req = 1'b1, lpm_from_boot = 1'b0;
    logic exec_in_boot = 1'b0, ivec_in_boot = 1'b0;
    logic erase_flash_pulse, erase_eeprom_pulse;
    logic spm_wr_allow, lpm_rd_allow, irq_allow, ocd_enable;
    logic sleep_clk_keep, scan_port_enable, serial_prog_enable;
    logic eeprom_preserve, brownout_level, brownout_enable;
    logic [1:0] boot_size;
    logic [15:0] reset_vector;
    logic [3:0] clock_select;
    int n_tests = 0, n_mismatch = 0, n_ef = 0, n_ee = 0;
    always #2.5 ref_clk = ~ref_clk;
    lfs_ctrl #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
        .CAL_BYTE(CAL)) uut (.ref_clk, .srst, .prog_mode_en,
        .crystal_input_strobe, .action_select_hi, .action_select_lo,
        .byte_select_one, .byte_select_two, .wr_n, .oe_n, .data_in,
        .data_out, .data_oe_n, .ready_busy_out, .ext_fuse_wr, .ext_fuse_hi,
        .ext_fuse_serial, .ext_fuse_data, .ext_sig_addr, .ext_sig_hi,
        .ext_sig_data, .nvm_wr_pulse(), .nvm_wr_eeprom(), .nvm_addr(),
        .nvm_wdata(), .erase_flash_pulse, .erase_eeprom_pulse, .spm_wr_req,
        .spm_to_boot, .lpm_rd_req, .lpm_from_boot, .exec_in_boot,
        .ivec_in_boot, .spm_wr_allow, .lpm_rd_allow, .irq_allow, .ocd_enable,
        .sleep_clk_keep, .scan_port_enable, .serial_prog_enable,
        .eeprom_preserve, .boot_size, .reset_vector, .brownout_level,
        .brownout_enable, .clock_select);
    lfs_prog_model pm (.ref_clk, .ready_busy_out, .data_out, .data_oe_n,
        .crystal_input_strobe, .action_select_hi, .action_select_lo,
        .byte_select_one, .wr_n, .oe_n, .data_in);
    always @(posedge ref_clk) begin
        if (erase_flash_pulse === 1'b1) n_ef++;
        if (erase_eeprom_pulse === 1'b1) n_ee++;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_core(input logic e_spm, e_lpm, e_irq);
        @(posedge ref_clk) exec_in_boot <= 1'b0;
        @(posedge ref_clk);
        chk(spm_wr_allow, e_spm);
        chk(lpm_rd_allow, e_lpm);
        exec_in_boot <= 1'b1;
        @(posedge ref_clk);
        chk(irq_allow, e_irq);
    endtask : chk_core
    task automatic prog(input logic [7:0] c, input logic bs1,
        input logic [7:0] d);
        int busy;
        pm.cmd(c);
        pm.xload(ACT_LOAD_DATA, 1'b0, d);
        pm.wr(bs1, busy);
        chk(16'(busy), 16'(PROG_BUSY_CYC));
    endtask : prog
    task automatic xfuse(input logic ser, input logic [7:0] d);
        @(posedge ref_clk);
        ext_fuse_wr <= 1'b1;
        ext_fuse_hi <= 1'b1;
        ext_fuse_serial <= ser;
        ext_fuse_data <= d;
        @(posedge ref_clk);
        ext_fuse_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : xfuse
    ////////////////////////////////////////
    task automatic t_reset();
        chk(ocd_enable, 1'b0);
        chk(sleep_clk_keep, 1'b0);
        chk(scan_port_enable, 1'b1);
        chk(serial_prog_enable, 1'b1);
        chk(eeprom_preserve, 1'b0);
        chk(boot_size, 2'h3);
        chk(reset_vector, RESET_VEC_APP);
        chk(brownout_level, 1'b1);
        chk(brownout_enable, 1'b0);
        chk(clock_select, 4'h2);
        chk_core(1'b1, 1'b1, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fuse();
        prog(CMD_WR_FUSE, 1'b1, 8'h20);
        chk(ocd_enable, 1'b0);
        chk(sleep_clk_keep, 1'b1);
        chk(scan_port_enable, 1'b0);
        chk(eeprom_preserve, 1'b1);
        chk(boot_size, 2'h0);
        chk(reset_vector, BOOT_START[0]);
        prog(CMD_WR_FUSE, 1'b1, 8'h08);
        chk(ocd_enable, 1'b1);
        prog(CMD_WR_FUSE, 1'b0, 8'h0f);
        chk(brownout_level, 1'b0);
        chk(brownout_enable, 1'b1);
        chk(clock_select, 4'hf);
        xfuse(1'b1, 8'h1a);
        chk(serial_prog_enable, 1'b1);
        chk(reset_vector, BOOT_START[1]);
        xfuse(1'b0, 8'h1a);
        chk(serial_prog_enable, 1'b0);
        $display("test fuse done");
    endtask : t_fuse
    task automatic t_lock();
        prog(CMD_WR_LOCK, 1'b0, 8'h2f);
        chk_core(1'b0, 1'b1, 1'b1);
        prog(CMD_WR_LOCK, 1'b0, 8'h0f);
        chk_core(1'b0, 1'b0, 1'b0);
        prog(CMD_CHIP_ERASE, 1'b0, 8'h00);
        chk(16'(n_ef), 16'h1);
        chk(16'(n_ee), 16'h1);
        chk(clock_select, 4'hf);
        chk(boot_size, 2'h1);
        chk_core(1'b1, 1'b1, 1'b1);
        prog(CMD_WR_LOCK, 1'b0, 8'h1f);
        chk_core(1'b1, 1'b0, 1'b0);
        prog(CMD_WR_FUSE, 1'b1, 8'h12);
        chk(eeprom_preserve, 1'b0);
        prog(CMD_WR_LOCK, 1'b0, 8'h1e);
        prog(CMD_WR_FUSE, 1'b0, 8'h32);
        chk(clock_select, 4'hf);
        xfuse(1'b1, 8'h1c);
        chk(boot_size, 2'h1);
        $display("test lock done");
    endtask : t_lock
    task automatic t_sig();
        logic [7:0] d;
        logic oen;
        int busy;
        pm.cmd(CMD_RD_SIG);
        for (int a = 0; a < 3; a++) begin
            pm.xload(ACT_LOAD_ADDR, 1'b0, 8'(a));
            pm.rd(1'b0, d, oen);
            chk(d, sig[a]);
            chk(oen, 1'b0);
            ext_sig_addr <= 2'(a);
            repeat (2) @(posedge ref_clk);
            chk(ext_sig_data, sig[a]);
        end
        pm.xload(ACT_LOAD_ADDR, 1'b0, 8'h00);
        pm.rd(1'b1, d, oen);
        chk(d, CAL);
        ext_sig_addr <= 2'h0;
        ext_sig_hi <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(ext_sig_data, CAL);
        pm.cmd(CMD_RD_FUSE_LOCK);
        pm.rd(1'b1, d, oen);
        chk(d, 8'h9a);
        byte_select_two <= 1'b1;
        pm.rd(1'b0, d, oen);
        chk(d, 8'hde);
        pm.cmd(8'h01);
        pm.wr(1'b0, busy);
        chk(16'(busy), 16'h0);
        $display("test signature done");
    endtask : t_sig
    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_fuse();
        t_lock();
        t_sig();
        tally_and_finish();
    end
    // The tests take some 23 us; a hang is cut off well beyond that.
    initial begin
        #100us;
        n_mismatch++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : test_lfs_ctrl
